//--- lqta_defs.svh
// Offsets, field positions and reset values of the threshold access block
`ifndef LQTA_DEFS_SVH
`define LQTA_DEFS_SVH

// Register indices; byte address is four times the index
`define LQTA_IDX_MONITOR   5'h1D
`define LQTA_IDX_ACCESS    5'h1E

// Access register fields
`define LQTA_RSVD_HI       15
`define LQTA_RSVD_LO       14
`define LQTA_SAMPLE_BIT    13
`define LQTA_TRIGGER_BIT   12
`define LQTA_SEL_HI        11
`define LQTA_SEL_LO        9
`define LQTA_HL_BIT        8
`define LQTA_DATA_HI       7
`define LQTA_DATA_LO       0

// Monitor control register fields
`define LQTA_MON_EN_BIT    15
`define LQTA_WARN_HI       9

// Reset values and threshold limits
`define LQTA_ACCESS_RST    16'h0000
`define LQTA_MON_RST       16'h0000
`define LQTA_THR_LOW_RST   8'h00
`define LQTA_THR_HIGH_RST  8'hFF
`define LQTA_THR_MIN       8'h00
`define LQTA_THR_MAX       8'hFF

// Bus responses
`define LQTA_RESP_OKAY     2'b00
`define LQTA_RESP_SLVERR   2'b10

`endif

//--- lqta_pkg.sv
// Types shared by the threshold access block
`default_nettype none
package lqta_pkg;

  typedef enum logic [2:0] {
    SEL_EQ_C1    = 3'b000,
    SEL_GAIN     = 3'b001,
    SEL_BASELINE = 3'b010,
    SEL_FREQ_OFS = 3'b011,
    SEL_FREQ_CTL = 3'b100
  } param_sel_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_t;

  typedef logic [4:0][7:0] param_bus_t;

endpackage : lqta_pkg

`default_nettype wire

//--- thr_bank_if.sv
// Carrier between the register front end and the threshold bank
`timescale 1ns/1ps
`default_nettype none

interface thr_bank_if;
  logic       wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  logic [9:0] exceed;

  modport ctrl (
    output wr_en, wr_addr, wr_data, rd_addr,
    input  rd_data, exceed
  );

  modport bank (
    input  wr_en, wr_addr, wr_data, rd_addr,
    output rd_data, exceed
  );
endinterface : thr_bank_if

`default_nettype wire

//--- thr_bank.sv
// Ten threshold slots and their comparisons against live parameters
`timescale 1ns/1ps
`default_nettype none
`include "lqta_defs.svh"

module thr_bank #(
  parameter int SLOTS = 10
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Live adapted parameters
  input  wire lqta_pkg::param_bus_t param_value,
  // Front end
  thr_bank_if.bank               bus
);
  import lqta_pkg::*;

  if (SLOTS != 10) begin : g_bad_slots
    $error("thr_bank serves exactly ten slots");
  end

  logic [7:0] slot_q [SLOTS];

  assign bus.rd_data = (bus.rd_addr < 4'(SLOTS)) ? slot_q[bus.rd_addr]
                                                 : 8'h00;

  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    localparam bit IS_HIGH = (i % 2) == 1;
    wire [7:0] live = param_value[i / 2];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        slot_q[i] <= IS_HIGH ? `LQTA_THR_HIGH_RST : `LQTA_THR_LOW_RST;
      end else if (bus.wr_en && bus.wr_addr == 4'(i)) begin
        slot_q[i] <= bus.wr_data;
      end
    end
    if (IS_HIGH) begin : g_hi
      assign bus.exceed[i] = (slot_q[i] != `LQTA_THR_MAX) &&
                             (live > slot_q[i]);
    end else begin : g_lo
      assign bus.exceed[i] = (slot_q[i] != `LQTA_THR_MIN) &&
                             (live < slot_q[i]);
    end
  end

endmodule : thr_bank

`default_nettype wire

//--- lq_threshold_access.sv
// Link quality threshold access register with AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lqta_defs.svh"

// Overview of operation
// - Bits 15:14 ignore writes and always read zero.
// - Writing sample bit one samples selected parameter; data reads values.
// - Writing trigger one stores data byte into addressed threshold slot, except while power_down is high.
// - Trigger bit is a pulse and always reads zero.
// - Three-bit select picks one of five adapted parameters.
// - Same select addresses sampling, threshold reads and threshold writes.
// - Threshold select bit: zero low threshold, one high threshold.
// - Select and low/high bit together address ten threshold slots.
// - With sample bit zero, written data byte is the threshold value.
// - With sample bit zero, reads return the addressed threshold.
// - With sample bit one, reads return a frozen sampled value.
// - High threshold at maximum or low threshold at minimum disables that comparison.
// - Exceeded threshold sets warning flag while monitor enabled and link up, cleared by reading monitor.

module lq_threshold_access #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Write address channel
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output logic                      awready,
  // Write data channel
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // Write response channel
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output logic                      arready,
  // Read data channel
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Receiver side, same clock
  input  wire lqta_pkg::param_bus_t param_value,
  input  wire logic                 link_100_up,
  input  wire logic                 power_down
);
  import lqta_pkg::*;

  // Reset images as constants; a literal cannot be bit-selected
  localparam logic [15:0] ACC_RST = `LQTA_ACCESS_RST;
  localparam logic [15:0] MON_RST = `LQTA_MON_RST;

  if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must hold byte address of index 1Eh");
  end

  thr_bank_if tb ();

  thr_bank #(
    .SLOTS       (10)
  ) u_bank (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .param_value (param_value),
    .bus         (tb.bank)
  );

  // Write side state
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;

  // Read side state
  rd_state_t         rd_state_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // Access register fields
  logic              sample_q;
  param_sel_t        sel_q;
  logic              hl_q;
  logic [7:0]        held_q;

  // Monitor control fields
  logic              mon_en_q;
  logic              link_up_q;
  logic [9:0]        warn_q;
  wire  [9:0]        warn_d;

  // Handshakes
  wire aw_take = awvalid && awready_q;
  wire w_take  = wvalid && wready_q;
  wire ar_take = arvalid && arready_q;
  wire do_write = aw_hold_q && w_hold_q && !bvalid_q;

  wire aw_hold_d = aw_take || (aw_hold_q && !do_write);
  wire w_hold_d  = w_take || (w_hold_q && !do_write);

  // Address decode
  wire [ADDR_W-3:0] aw_word = awaddr_q[ADDR_W-1:2];
  wire [ADDR_W-3:0] ar_word = araddr[ADDR_W-1:2];
  wire wr_access  = aw_word == (ADDR_W-2)'(`LQTA_IDX_ACCESS);
  wire wr_monitor = aw_word == (ADDR_W-2)'(`LQTA_IDX_MONITOR);
  wire rd_access  = ar_word == (ADDR_W-2)'(`LQTA_IDX_ACCESS);
  wire rd_monitor = ar_word == (ADDR_W-2)'(`LQTA_IDX_MONITOR);
  wire wr_mapped  = wr_access || wr_monitor;
  wire rd_mapped  = rd_access || rd_monitor;

  wire [15:0] acc_cur = {2'b00, sample_q, 1'b0, sel_q, hl_q, 8'h00};
  wire [7:0]  hi_byte = wstrb_q[1] ? wdata_q[15:8] : acc_cur[15:8];

  wire        new_sample = hi_byte[`LQTA_SAMPLE_BIT-8];
  wire [2:0]  new_sel    = hi_byte[`LQTA_SEL_HI-8:`LQTA_SEL_LO-8];
  wire        new_hl     = hi_byte[`LQTA_HL_BIT-8];
  wire        sel_ok     = new_sel <= SEL_FREQ_CTL;

  wire acc_write = do_write && wr_access;
  wire mon_write = do_write && wr_monitor;
  // Upper byte lane carries every control bit
  wire acc_hi_we = acc_write && wstrb_q[1];
  wire mon_hi_we = mon_write && wstrb_q[1];

  wire trigger = acc_hi_we && wdata_q[`LQTA_TRIGGER_BIT];

  wire thr_write = trigger && !power_down && sel_ok;

  // slot index is select then low/high
  assign tb.wr_addr = {new_sel, new_hl};
  // read slot follows the stored select
  assign tb.rd_addr = {sel_q, hl_q};
  assign tb.wr_data = wdata_q[`LQTA_DATA_HI:`LQTA_DATA_LO];
  assign tb.wr_en   = thr_write;

  wire sample_write = acc_write && new_sample;
  wire [7:0] live_sel = sel_ok ? param_value[new_sel] : 8'h00;

  // warnings gated by enable and link
  wire       warn_arm = mon_en_q && link_up_q;
  wire [9:0] warn_set = tb.exceed & {10{warn_arm}};
  wire       warn_clr = ar_take && rd_monitor;

  // one sticky flag per threshold; set wins over clear
  for (genvar f = 0; f < 10; f++) begin : g_warn
    assign warn_d[f] = warn_set[f] || (warn_q[f] && !warn_clr);
  end

  wire [7:0] data_rd = sample_q ? held_q : tb.rd_data;

  wire [15:0] acc_rd = {2'b00, sample_q, 1'b0, sel_q, hl_q, data_rd};
  wire [15:0] mon_rd = {mon_en_q, 5'b00000, warn_q};

  wire [31:0] acc_word = {16'h0000, acc_rd};
  wire [31:0] mon_word = {16'h0000, mon_rd};

  // Unmapped words read as zero with an error response
  wire [31:0] rd_word = rd_access  ? acc_word :
                        rd_monitor ? mon_word :
                                     32'h0000_0000;

  // Write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      awready_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      awready_q <= !aw_hold_d;
      if (aw_take) begin
        awaddr_q <= awaddr;
      end
    end
  end

  // Write data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      wready_q <= 1'b0;
    end else begin
      w_hold_q <= w_hold_d;
      wready_q <= !w_hold_d;
      if (w_take) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // Write response; unmapped gets an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `LQTA_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? `LQTA_RESP_OKAY : `LQTA_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Access register fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_q <= ACC_RST[`LQTA_SAMPLE_BIT];
      sel_q    <= param_sel_t'(ACC_RST[`LQTA_SEL_HI:`LQTA_SEL_LO]);
      hl_q     <= ACC_RST[`LQTA_HL_BIT];
    end else if (acc_hi_we) begin
      sample_q <= new_sample;
      sel_q    <= param_sel_t'(new_sel);
      hl_q     <= new_hl;
    end
  end

  // Sampled value stays frozen between sample writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q <= 8'h00;
    end else if (sample_write) begin
      held_q <= live_sel;
    end
  end

  // Link qualifier registered to break the compare path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_up_q <= 1'b0;
    end else begin
      link_up_q <= link_100_up;
    end
  end

  // Monitor control and warning flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_en_q <= MON_RST[`LQTA_MON_EN_BIT];
      warn_q   <= 10'h000;
    end else begin
      warn_q <= warn_d;
      if (mon_hi_we) begin
        mon_en_q <= wdata_q[`LQTA_MON_EN_BIT];
      end
    end
  end

  // Read channel: one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= RD_IDLE;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `LQTA_RESP_OKAY;
    end else begin
      unique case (rd_state_q)
        RD_IDLE: begin
          arready_q <= 1'b1;
          if (ar_take) begin
            rd_state_q <= RD_RESP;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b1;
            rdata_q    <= rd_word;
            rresp_q    <= rd_mapped ? `LQTA_RESP_OKAY
                                    : `LQTA_RESP_SLVERR;
          end
        end
        RD_RESP: begin
          if (rready) begin
            rd_state_q <= RD_IDLE;
            rvalid_q   <= 1'b0;
            arready_q  <= 1'b1;
          end
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

endmodule : lq_threshold_access

`default_nettype wire

//--- lqta_checker.sv
// Bus and field assertions for the threshold access register
`timescale 1ns/1ps
`default_nettype none
`include "lqta_defs.svh"

module lqta_checker #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Write channels
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  // Read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid
);
  localparam logic [ADDR_W-1:0] A_ACC = ADDR_W'({`LQTA_IDX_ACCESS, 2'b00});
  localparam logic [ADDR_W-1:0] A_MON = ADDR_W'({`LQTA_IDX_MONITOR, 2'b00});
  logic      acc_q;
  wire logic ar_hs  = arvalid && arready;
  wire logic mapped = (araddr == A_ACC) || (araddr == A_MON);

  // Remembers which register the pending read targets
  always_ff @(posedge aclk) begin
    if (!aresetn) acc_q <= 1'b0;
    else if (ar_hs) acc_q <= (araddr == A_ACC);
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_upper_half_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_rsvd_read_zero: assert property (
    rvalid && acc_q |-> rdata[15:14] == 2'b00)
    else $error("reserved bits read nonzero");
  a_trig_read_zero: assert property (
    rvalid && acc_q |-> !rdata[12])
    else $error("trigger bit read as one");
  a_read_answer: assert property (ar_hs |=> rvalid)
    else $error("read not answered next cycle");
  a_ar_busy: assert property (rvalid |-> !arready)
    else $error("read address accepted while busy");
  a_unmapped_err: assert property (ar_hs && !mapped |=>
    rresp == `LQTA_RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (ar_hs && mapped |=> rresp == `LQTA_RESP_OKAY)
    else $error("mapped read not okay");
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");

  c_write: cover property (awvalid && awready && wvalid && wready);
  c_unmapped: cover property (ar_hs && !mapped);
  c_sample_read: cover property (rvalid && acc_q && rdata[13]);
  c_warn_read: cover property (rvalid && !acc_q && rdata[9:0] != 10'h000);
endmodule : lqta_checker

bind lq_threshold_access lqta_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid
);

`default_nettype wire

//--- tb.sv
// Self-checking bench for the threshold access register
`timescale 1ns/1ps
`default_nettype none
`include "lqta_defs.svh"

module tb;
  import lqta_pkg::*;
  localparam logic [7:0] A_ACC = {1'b0, `LQTA_IDX_ACCESS, 2'b00};
  localparam logic [7:0] A_MON = {1'b0, `LQTA_IDX_MONITOR, 2'b00};
  logic        aclk = 1'b0, aresetn = 1'b0, link_100_up = 1'b1;
  logic        power_down = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  param_bus_t  param_value = {5{8'h80}};
  int          bad_count = 0, total_checks = 0;

  always #20 aclk = ~aclk;

  lq_threshold_access u_dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .param_value, .link_100_up, .power_down
  );

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bounded waits only; a stuck slave ends the run
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bit b = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= {16'h0000, d};
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 100 && !b; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        b = 1;
        bready <= 1'b0;
        chk("bresp", {30'h0, (a == A_ACC || a == A_MON) ? 2'b00 : 2'b10},
            {30'h0, bresp});
      end
    end
    if (!b) begin
      chk("write handshake", 1, 0);
      print_verdict;
    end
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bit b = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 100 && !b; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        b = 1;
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, (a == A_ACC || a == A_MON) ? 2'b00 : 2'b10},
            {30'h0, rresp});
      end
    end
    if (!b) begin
      chk("read handshake", 1, 0);
      print_verdict;
    end
  endtask : rchk

  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  task automatic t_defaults;
    rchk(A_ACC, 32'h0000);
    wr(A_ACC, 16'hC100);
    rchk(A_ACC, 32'h01FF);
    wr(A_ACC, 16'hC000);
    rchk(A_ACC, 32'h0000);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_slots;
    logic [7:0] dv;
    for (int k = 0; k < 10; k++) begin
      dv = 8'h11 * 8'(k + 1);
      wr(A_ACC, {4'b1101, 4'(k), dv});
      rchk(A_ACC, {20'h0, 4'(k), dv});
    end
    $display("test slots done");
  endtask : t_slots

  task automatic t_sample;
    for (int k = 0; k < 5; k++) begin
      @(posedge aclk);
      param_value[k] <= 8'h30 + 8'(k);
      wr(A_ACC, {4'b1110, 3'(k), 9'h000});
      rchk(A_ACC, {18'h0, 2'b10, 3'(k), 1'b0, 8'h30 + 8'(k)});
      @(posedge aclk);
      param_value[k] <= 8'hC0 + 8'(k);
      rchk(A_ACC, {18'h0, 2'b10, 3'(k), 1'b0, 8'h30 + 8'(k)});
      wr(A_ACC, {4'b0010, 3'(k), 9'h000});
      rchk(A_ACC, {18'h0, 2'b10, 3'(k), 1'b0, 8'hC0 + 8'(k)});
    end
    $display("test sample done");
  endtask : t_sample

  // Only the gain value is out of range; others sit at 00/FF thresholds
  task automatic t_monitor;
    @(posedge aclk);
    param_value[1] <= 8'h50;
    link_100_up <= 1'b0;
    wr(A_ACC, 16'h1340);
    wr(A_MON, 16'h8000);
    repeat (4) @(posedge aclk);
    rchk(A_MON, 32'h8000);
    link_100_up <= 1'b1;
    repeat (4) @(posedge aclk);
    param_value[1] <= 8'h30;
    repeat (4) @(posedge aclk);
    rchk(A_MON, 32'h8008);
    rchk(A_MON, 32'h8000);
    $display("test monitor done");
  endtask : t_monitor

  // Threshold written while powered down must not land
  task automatic t_power;
    @(posedge aclk);
    power_down <= 1'b1;
    wr(A_ACC, 16'h125A);
    @(posedge aclk);
    power_down <= 1'b0;
    rchk(A_ACC, 32'h0233);
    $display("test power done");
  endtask : t_power

  task automatic t_unmapped;
    rchk(8'h00, 32'h0000);
    wr(8'h40, 16'h1FFF);
    rchk(A_ACC, 32'h28C4);
    $display("test unmapped done");
  endtask : t_unmapped

  initial begin
    rst();
    t_defaults();
    t_slots();
    t_power();
    t_sample();
    t_unmapped();
    rst();
    t_defaults();
    t_monitor();
    print_verdict();
  end
endmodule : tb

`default_nettype wire
